// file: shared/ppdc_pkg.sv
// Purpose: constants for the port pull, drive and bus clock register bank
// Assumes: AXI4-Lite 32-bit data, one word per register
// Notes:   register indices are word indices, byte address is four times
package ppdc_pkg;

    // ********************************************************
    // register map
    // ********************************************************
    localparam logic [3:0]  IDX_PULL     = 4'hc;
    localparam logic [3:0]  IDX_DRIVE    = 4'hd;
    localparam logic [3:0]  IDX_BUSCLK   = 4'he;
    localparam logic [3:0]  IDX_RSVD     = 4'hf;
    localparam int          RELOC_SHIFT  = 8;
    localparam int          IDX_LSB      = 2;

    // ********************************************************
    // fields, masks and reset values
    // ********************************************************
    localparam int          BIT_PORT_K   = 7;
    localparam int          BIT_PORT_E   = 4;
    localparam int          BIT_PORT_B   = 1;
    localparam int          BIT_PORT_A   = 0;
    localparam int          BIT_STRETCH  = 0;
    localparam logic [7:0]  PULL_MASK    = 8'h93;
    localparam logic [7:0]  DRIVE_MASK   = 8'h93;
    localparam logic [7:0]  BUSCLK_MASK  = 8'h01;
    localparam logic [7:0]  PULL_RESET   = 8'h00;
    localparam logic [7:0]  DRIVE_RESET  = 8'h00;
    localparam logic [7:0]  BUSCLK_RESET = 8'h00;
    // port e pins steered by the port e pull bit
    localparam logic [7:0]  PORT_E_PULL_PINS  = 8'h9f;
    // port e pins pulled only while reset is applied
    localparam logic [7:0]  PORT_E_RESET_PINS = 8'h60;

    // ********************************************************
    // bus answers and timing
    // ********************************************************
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_DECERR  = 2'h3;
    localparam int          CLK_MHZ      = 100;
    localparam int          EBUS_HALF_NS = 20;
    localparam int          EBUS_HALF_CYC = (EBUS_HALF_NS * CLK_MHZ) / 1000;

    // ********************************************************
    // operating modes from the three mode select bits (c,b,a)
    // ********************************************************
    function automatic logic mode_single_chip(input logic [2:0] m);
        mode_single_chip = (m[0] == 1'b0) && (m[1] == 1'b0);
    endfunction : mode_single_chip

    function automatic logic mode_expanded(input logic [2:0] m);
        mode_expanded = m[0];
    endfunction : mode_expanded

    function automatic logic mode_peripheral(input logic [2:0] m);
        mode_peripheral = (m == 3'h6);
    endfunction : mode_peripheral

    // special modes have mode bits c and a clear, or are peripheral
    function automatic logic mode_special(input logic [2:0] m);
        mode_special = (!m[2] && !m[0]) || (m == 3'h6);
    endfunction : mode_special

endpackage : ppdc_pkg

// file: src/ppdc_top.sv
// Purpose: pull enable, reduced drive and bus clock control register bank
// Assumes: one clock, mode bits and relocation from the same clock domain
// Notes:   registers leave the map in expanded and peripheral modes
`timescale 1ns/1ns

module ppdc_top
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [2:0]  mode_select_bits,
    input  wire logic [7:0]  register_block_relocation,
    input  wire logic [7:0]  port_a_dir,
    input  wire logic [7:0]  port_b_dir,
    input  wire logic [7:0]  port_e_dir,
    input  wire logic [7:0]  port_k_dir,
    input  wire logic        ext_access_stretched,
    input  wire logic        int_access_hidden,
    output logic [7:0]       port_a_pull_en,
    output logic [7:0]       port_b_pull_en,
    output logic [7:0]       port_e_pull_en,
    output logic [7:0]       port_k_pull_en,
    output logic [3:0]       reduced_drive_en,
    output logic             ext_bus_clk,
    output logic             ext_echo,
    output logic [31:0]      ext_echo_addr
);

    // ********************************************************
    // address decode
    // ********************************************************
    // returns {hit, index} for a byte address against the relocated base
    function automatic logic [4:0] reg_decode(input logic [31:0] addr,
                                              input logic [7:0]  reloc);
        logic [31:0] base;
        logic [31:0] offs;
        base = 32'(reloc) << ppdc_pkg::RELOC_SHIFT;
        offs = addr - base;
        reg_decode = {1'b0, offs[ppdc_pkg::IDX_LSB+3:ppdc_pkg::IDX_LSB]};
        if (offs[31:ppdc_pkg::IDX_LSB+4] == '0 &&
            offs[ppdc_pkg::IDX_LSB+3:ppdc_pkg::IDX_LSB+2] == 2'h3)
            reg_decode[4] = 1'b1;
    endfunction : reg_decode

    logic        clock_stretch_enable_ff;
    logic        clock_stretch_enable_locked_ff;
    logic [7:0]  pull_ctl_ff;
    logic [7:0]  drive_ctl_ff;
    logic        aw_have_ff;
    logic        w_have_ff;
    logic [31:0] aw_addr_ff;
    logic [7:0]  w_data_ff;
    logic        w_lane0_ff;
    logic        awready_ff;
    logic        wready_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        arready_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic        echo_ff;
    logic [31:0] echo_addr_ff;
    logic [7:0]  pull_a_ff;
    logic [7:0]  pull_b_ff;
    logic [7:0]  pull_e_ff;
    logic [7:0]  pull_k_ff;
    logic [3:0]  rdrv_ff;
    logic [1:0]  ediv_ff;
    logic        ephase_ff;
    logic        eclk_ff;

    wire logic        in_map;
    wire logic        is_special;
    wire logic        single_chip;
    wire logic        aw_take;
    wire logic        w_take;
    wire logic        ar_take;
    wire logic        do_wr;
    wire logic [4:0]  wr_dec;
    wire logic [4:0]  rd_dec;
    wire logic        wr_hit;
    wire logic        rd_hit;
    wire logic        wr_ok;
    wire logic        wr_pull;
    wire logic        wr_drive;
    wire logic        wr_busclk;
    wire logic        clock_stretch_enable_wr_allowed;
    wire logic        clock_stretch_enable_eff;
    wire logic [7:0]  rd_val;
    wire logic        nxt_aw_have;
    wire logic        nxt_w_have;
    wire logic        nxt_bvalid;
    wire logic        nxt_rvalid;
    wire logic        ediv_wrap;
    wire logic        nxt_eclk;

    // ********************************************************
    // mode and map presence
    // ********************************************************
    assign single_chip = ppdc_pkg::mode_single_chip(mode_select_bits);
    assign is_special  = ppdc_pkg::mode_special(mode_select_bits);
    assign in_map      = !ppdc_pkg::mode_expanded(mode_select_bits) &&
                         !ppdc_pkg::mode_peripheral(mode_select_bits);

    // ********************************************************
    // axi4-lite handshakes
    // ********************************************************
    assign aw_take     = s_axi_awvalid && awready_ff;
    assign w_take      = s_axi_wvalid && wready_ff;
    assign ar_take     = s_axi_arvalid && arready_ff;
    assign do_wr       = aw_have_ff && w_have_ff && !bvalid_ff;
    assign nxt_aw_have = (aw_have_ff || aw_take) && !do_wr;
    assign nxt_w_have  = (w_have_ff || w_take) && !do_wr;
    assign nxt_bvalid  = do_wr || (bvalid_ff && !s_axi_bready);
    assign nxt_rvalid  = ar_take || (rvalid_ff && !s_axi_rready);

    assign wr_dec    = reg_decode(aw_addr_ff, register_block_relocation);
    assign rd_dec    = reg_decode(s_axi_araddr, register_block_relocation);
    assign wr_hit    = wr_dec[4];
    assign rd_hit    = rd_dec[4];
    assign wr_ok     = do_wr && wr_hit && in_map && w_lane0_ff;
    assign wr_pull   = wr_ok && (wr_dec[3:0] == ppdc_pkg::IDX_PULL);
    assign wr_drive  = wr_ok && (wr_dec[3:0] == ppdc_pkg::IDX_DRIVE);
    assign wr_busclk = wr_ok && (wr_dec[3:0] == ppdc_pkg::IDX_BUSCLK);
    // special modes rewrite freely; otherwise the first write locks it
    assign clock_stretch_enable_wr_allowed = is_special || !clock_stretch_enable_locked_ff;

    // reserved slot and unknown indices fall through to zero
    assign rd_val =
        (rd_dec[3:0] == ppdc_pkg::IDX_PULL)   ? pull_ctl_ff  :
        (rd_dec[3:0] == ppdc_pkg::IDX_DRIVE)  ? drive_ctl_ff :
        (rd_dec[3:0] == ppdc_pkg::IDX_BUSCLK) ?
            {7'h00, clock_stretch_enable_ff} : 8'h00;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
            aw_addr_ff <= 32'h0000_0000;
            w_data_ff  <= 8'h00;
            w_lane0_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= ppdc_pkg::RESP_OKAY;
        end
        else
        begin
            aw_have_ff <= nxt_aw_have;
            w_have_ff  <= nxt_w_have;
            awready_ff <= !nxt_aw_have && !nxt_bvalid;
            wready_ff  <= !nxt_w_have && !nxt_bvalid;
            bvalid_ff  <= nxt_bvalid;
            if (aw_take)
                aw_addr_ff <= s_axi_awaddr;
            if (w_take)
            begin
                w_data_ff  <= s_axi_wdata[7:0];
                w_lane0_ff <= s_axi_wstrb[0];
            end
            if (do_wr)
                bresp_ff <= (wr_hit && in_map) ? ppdc_pkg::RESP_OKAY :
                            ppdc_pkg::RESP_DECERR;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= ppdc_pkg::RESP_OKAY;
        end
        else
        begin
            arready_ff <= !nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            if (ar_take)
            begin
                // upper bits of every word read as zero
                rdata_ff <= (rd_hit && in_map) ?
                            {24'h000000, rd_val} : 32'h0000_0000;
                rresp_ff <= (rd_hit && in_map) ? ppdc_pkg::RESP_OKAY :
                            ppdc_pkg::RESP_DECERR;
            end
        end
    end

    // unmapped bank reads and writes pulse the external bus echo; a read taken in the same cycle as a write sets the echo address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            echo_ff      <= 1'b0;
            echo_addr_ff <= 32'h0000_0000;
        end
        else
        begin
            echo_ff <= (ar_take && rd_hit && !in_map) ||
                       (do_wr && wr_hit && !in_map);
            if (ar_take)
                echo_addr_ff <= s_axi_araddr;
            else if (do_wr)
                echo_addr_ff <= aw_addr_ff;
        end
    end

    // ********************************************************
    // control registers
    // ********************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pull_ctl_ff    <= ppdc_pkg::PULL_RESET;
            drive_ctl_ff   <= ppdc_pkg::DRIVE_RESET;
            clock_stretch_enable_ff        <= ppdc_pkg::BUSCLK_RESET[0];
            clock_stretch_enable_locked_ff <= 1'b0;
        end
        else
        begin
            if (wr_pull)
                pull_ctl_ff <= w_data_ff & ppdc_pkg::PULL_MASK;
            if (wr_drive)
                drive_ctl_ff <= w_data_ff & ppdc_pkg::DRIVE_MASK;
            if (wr_busclk && clock_stretch_enable_wr_allowed)
                clock_stretch_enable_ff <= w_data_ff[ppdc_pkg::BIT_STRETCH];
            if (wr_busclk && !is_special)
                clock_stretch_enable_locked_ff <= 1'b1;
        end
    end

    // ********************************************************
    // pin controls
    // ********************************************************
    // direction bit 1 means output, so pulls follow the inverted direction
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pull_a_ff <= 8'h00;
            pull_b_ff <= 8'h00;
            pull_e_ff <= ppdc_pkg::PORT_E_RESET_PINS;
            pull_k_ff <= 8'h00;
            rdrv_ff   <= 4'h0;
        end
        else
        begin
            pull_a_ff <= {8{pull_ctl_ff[ppdc_pkg::BIT_PORT_A]}} &
                         ~port_a_dir;
            pull_b_ff <= {8{pull_ctl_ff[ppdc_pkg::BIT_PORT_B]}} &
                         ~port_b_dir;
            pull_e_ff <= {8{pull_ctl_ff[ppdc_pkg::BIT_PORT_E]}} &
                         ~port_e_dir & ppdc_pkg::PORT_E_PULL_PINS;
            pull_k_ff <= {8{pull_ctl_ff[ppdc_pkg::BIT_PORT_K]}} &
                         ~port_k_dir;
            // no function gating: drive follows the bits alone
            rdrv_ff   <= {drive_ctl_ff[ppdc_pkg::BIT_PORT_K],
                          drive_ctl_ff[ppdc_pkg::BIT_PORT_E],
                          drive_ctl_ff[ppdc_pkg::BIT_PORT_B],
                          drive_ctl_ff[ppdc_pkg::BIT_PORT_A]};
        end
    end

    // ********************************************************
    // external bus clock
    // ********************************************************
    assign ediv_wrap = (ediv_ff == 2'(ppdc_pkg::EBUS_HALF_CYC - 1));
    assign clock_stretch_enable_eff  = clock_stretch_enable_ff && !single_chip;
    assign nxt_eclk  = !clock_stretch_enable_eff             ? ephase_ff :
                       ext_access_stretched ? 1'b1 :
                       int_access_hidden    ? 1'b0 : ephase_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ediv_ff   <= 2'h0;
            ephase_ff <= 1'b0;
            eclk_ff   <= 1'b0;
        end
        else
        begin
            ediv_ff   <= ediv_wrap ? 2'h0 : ediv_ff + 2'h1;
            if (ediv_wrap)
                ephase_ff <= !ephase_ff;
            eclk_ff   <= nxt_eclk;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign s_axi_awready    = awready_ff;
    assign s_axi_wready     = wready_ff;
    assign s_axi_bvalid     = bvalid_ff;
    assign s_axi_bresp      = bresp_ff;
    assign s_axi_arready    = arready_ff;
    assign s_axi_rvalid     = rvalid_ff;
    assign s_axi_rdata      = rdata_ff;
    assign s_axi_rresp      = rresp_ff;
    assign port_a_pull_en   = pull_a_ff;
    assign port_b_pull_en   = pull_b_ff;
    assign port_e_pull_en   = pull_e_ff;
    assign port_k_pull_en   = pull_k_ff;
    assign reduced_drive_en = rdrv_ff;
    assign ext_bus_clk      = eclk_ff;
    assign ext_echo         = echo_ff;
    assign ext_echo_addr    = echo_addr_ff;

    // ********************************************************
    // checks
    // ********************************************************
    rsvd_reads_zero_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ar_take && rd_hit && rd_dec[3:0] == ppdc_pkg::IDX_RSVD)
        |=> (rvalid_ff && rdata_ff == 32'h0000_0000))
        else $error("reserved slot read not zero");

    pull_unused_zero_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (pull_ctl_ff & ~ppdc_pkg::PULL_MASK) == 8'h00 &&
        (drive_ctl_ff & ~ppdc_pkg::DRIVE_MASK) == 8'h00)
        else $error("unimplemented control bit set");

    pull_write_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_pull |=> pull_ctl_ff == ($past(w_data_ff) & ppdc_pkg::PULL_MASK))
        else $error("pull register write lost");

    unmapped_echo_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ar_take && rd_hit && !in_map)
        |=> (echo_ff && rresp_ff == ppdc_pkg::RESP_DECERR))
        else $error("unmapped access not echoed");

    port_k_pull_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ##1 pull_k_ff == ($past(pull_ctl_ff[ppdc_pkg::BIT_PORT_K]) ?
                          ~$past(port_k_dir) : 8'h00))
        else $error("port k pull mismatch");

    port_e_pins_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        aresetn |=> (pull_e_ff & ppdc_pkg::PORT_E_RESET_PINS) == 8'h00)
        else $error("port e reset-only pulls active");

    stretch_lock_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (clock_stretch_enable_locked_ff && !is_special) |=> $stable(clock_stretch_enable_ff))
        else $error("stretch enable rewritten after lock");

    free_run_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (!clock_stretch_enable_ff || single_chip) |=> eclk_ff == $past(ephase_ff))
        else $error("bus clock not free running");

    stretch_high_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (clock_stretch_enable_ff && !single_chip && ext_access_stretched) |=> eclk_ff)
        else $error("bus clock low during stretched access");

endmodule : ppdc_top

// file: testbench/ppdc_pad_model.sv
// Purpose: pad side of the port pins and the bus clock pin
// Assumes: a pulled pin reads high, a floating pin wanders
// Notes:   counts bus clock rising edges as sampled by aclk
`timescale 1ns/1ns
module ppdc_pad_model
(
    input  wire logic        aclk,
    input  wire logic [7:0]  pull_en,
    input  wire logic        ext_bus_clk,
    output logic      [7:0]  pin,
    output logic      [15:0] clk_edges
);
    logic last_clk_ff;
    initial
    begin
        pin = 8'h00;
        clk_edges = 16'h0;
        last_clk_ff = 1'b0;
    end
    // floating pins toggle so a missing pull cannot hide
    always @(posedge aclk)
    begin
        pin         <= pull_en | ~pin;
        last_clk_ff <= ext_bus_clk;
        clk_edges   <= clk_edges + 16'(ext_bus_clk & ~last_clk_ff);
    end
endmodule : ppdc_pad_model

// file: testbench/ppdc_top_bench.sv
// Purpose: self-checking bench for the pull, drive and bus clock bank
// Assumes: AXI4-Lite master changes signals just after aclk rises
// Notes:   mode and relocation change only while the bus is idle
`timescale 1ns/1ns
module ppdc_top_bench;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, stretched;
    logic        hidden, echo, ebclk;
    logic [31:0] awaddr, wdata, araddr, rdata, eaddr, echo_addr;
    logic [1:0]  bresp, rresp;
    logic [2:0]  md;
    logic [7:0]  rl, da, db, de, dk, pa, pb, pe, pk, pin;
    logic [3:0]  rdrv, wstrb;
    logic [15:0] edges;
    int          errors, cmp_count, cyc, echo_n;
    localparam logic [1:0] OK = ppdc_pkg::RESP_OKAY;
    localparam logic [1:0] DE = ppdc_pkg::RESP_DECERR;

    ppdc_top dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .mode_select_bits(md), .register_block_relocation(rl),
        .port_a_dir(da), .port_b_dir(db), .port_e_dir(de), .port_k_dir(dk),
        .ext_access_stretched(stretched), .int_access_hidden(hidden),
        .port_a_pull_en(pa), .port_b_pull_en(pb), .port_e_pull_en(pe),
        .port_k_pull_en(pk), .reduced_drive_en(rdrv), .ext_bus_clk(ebclk),
        .ext_echo(echo), .ext_echo_addr(eaddr));
    ppdc_pad_model pads (.aclk(aclk), .pull_en(pa), .ext_bus_clk(ebclk),
        .pin(pin), .clk_edges(edges));

    // ********************************************************
    // bus tasks and checks
    // ********************************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    function automatic logic [31:0] ad(input logic [3:0] i);
        return {16'h0, rl, 8'h00} + {26'h0, i, 2'b00};
    endfunction : ad
    task automatic wc(input logic [3:0] i, input logic [7:0] d,
                      input logic [1:0] er);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        awaddr  <= ad(i);
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(ta && tw))
        begin
            @(posedge aclk);
            if (!ta && awready === 1'b1) awvalid <= 1'b0;
            if (!tw && wready === 1'b1) wvalid <= 1'b0;
            ta = ta | (awready === 1'b1);
            tw = tw | (wready === 1'b1);
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk({30'h0, bresp}, {30'h0, er}, "bresp");
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wc
    task automatic rd(input logic [31:0] a, input logic [7:0] e,
                      input logic [1:0] er);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        chk(rdata, {24'h0, e}, "rdata");
        chk({30'h0, rresp}, {30'h0, er}, "rresp");
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task automatic ck_clk(input logic [15:0] e);
        logic [15:0] s;
        repeat (3) @(posedge aclk);
        s = edges;
        repeat (40) @(posedge aclk);
        chk({16'h0, edges - s}, {16'h0, e}, "bus clock edges");
    endtask : ck_clk
    task automatic rst(input logic [2:0] m);
        md      <= m;
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        chk({24'h0, pe}, 32'h60, "reset pulls");
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : rst
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic t_map;
        rst(3'h4);
        for (int i = 12; i < 16; i++) rd(ad(4'(i)), 8'h00, OK);
        wc(ppdc_pkg::IDX_RSVD, 8'hff, OK);
        rd(ad(ppdc_pkg::IDX_RSVD), 8'h00, OK);
        wc(4'h0, 8'h01, DE);
        rd(ad(4'h0), 8'h00, DE);
        $display("test map done");
    endtask : t_map
    task automatic t_pins;
        wc(ppdc_pkg::IDX_PULL, 8'hff, OK);
        rd(ad(ppdc_pkg::IDX_PULL), 8'h93, OK);
        db <= 8'h0f;
        dk <= 8'hf0;
        repeat (3) @(posedge aclk);
        chk({pa, pb, pe, pk}, 32'hfff09f0f, "pulls");
        chk({24'h0, pin}, 32'hff, "pad a");
        wc(ppdc_pkg::IDX_PULL, 8'h00, OK);
        wc(ppdc_pkg::IDX_DRIVE, 8'h10, OK);
        chk({pa, pb, pe, pk}, 32'h0, "pulls off");
        chk({28'h0, rdrv}, 32'h4, "drive e");
        wc(ppdc_pkg::IDX_DRIVE, 8'hff, OK);
        rd(ad(ppdc_pkg::IDX_DRIVE), 8'h93, OK);
        chk({28'h0, rdrv}, 32'hf, "drive all");
        wstrb <= 4'h0;
        wc(ppdc_pkg::IDX_DRIVE, 8'h00, OK);
        wstrb <= 4'h1;
        rd(ad(ppdc_pkg::IDX_DRIVE), 8'h93, OK);
        $display("test pins done");
    endtask : t_pins
    task automatic t_reloc;
        rl <= 8'h12;
        @(posedge aclk);
        wc(ppdc_pkg::IDX_PULL, 8'h01, OK);
        rd(ad(ppdc_pkg::IDX_PULL), 8'h01, OK);
        rd(32'h30, 8'h00, DE);
        rl <= 8'h00;
        @(posedge aclk);
        $display("test reloc done");
    endtask : t_reloc
    task automatic t_clk;
        wc(ppdc_pkg::IDX_BUSCLK, 8'h01, OK);
        wc(ppdc_pkg::IDX_BUSCLK, 8'h00, OK);
        rd(ad(ppdc_pkg::IDX_BUSCLK), 8'h01, OK);
        stretched <= 1'b1;
        ck_clk(16'd10);
        rst(3'h2);
        rd(ad(ppdc_pkg::IDX_BUSCLK), 8'h00, OK);
        wc(ppdc_pkg::IDX_BUSCLK, 8'h01, OK);
        ck_clk(16'd0);
        chk({31'h0, ebclk}, 32'h1, "stretch high");
        stretched <= 1'b0;
        hidden    <= 1'b1;
        ck_clk(16'd0);
        chk({31'h0, ebclk}, 32'h0, "hidden low");
        hidden <= 1'b0;
        ck_clk(16'd10);
        wc(ppdc_pkg::IDX_BUSCLK, 8'h00, OK);
        stretched <= 1'b1;
        ck_clk(16'd10);
        stretched <= 1'b0;
        rst(3'h4);
        wc(ppdc_pkg::IDX_BUSCLK, 8'h01, OK);
        rd(ad(ppdc_pkg::IDX_BUSCLK), 8'h01, OK);
        $display("test clock done");
    endtask : t_clk
    task automatic t_unmap;
        int n;
        for (int m = 5; m < 7; m++)
        begin
            md <= 3'(m);
            @(posedge aclk);
            n = echo_n;
            rd(ad(ppdc_pkg::IDX_PULL), 8'h00, DE);
            wc(ppdc_pkg::IDX_PULL, 8'hff, DE);
            repeat (2) @(posedge aclk);
            chk(echo_n - n, 32'd2, "echo count");
            chk(echo_addr, ad(ppdc_pkg::IDX_PULL), "echo addr");
        end
        md <= 3'h4;
        @(posedge aclk);
        rd(ad(ppdc_pkg::IDX_PULL), 8'h00, OK);
        $display("test unmap done");
    endtask : t_unmap

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        if (echo === 1'b1)
        begin
            echo_n    <= echo_n + 1;
            echo_addr <= eaddr;
        end
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            tally_and_finish();
        end
    end
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, stretched, hidden} = '0;
        {awaddr, wdata, araddr, echo_addr} = '0;
        wstrb = 4'h1;
        {md, rl, da, db, de, dk} = '0;
        aresetn = 1'b0;
        errors = 0;
        cmp_count = 0;
        cyc = 0;
        echo_n = 0;
        @(posedge aclk);
        t_map();
        t_pins();
        t_reloc();
        t_clk();
        t_unmap();
        tally_and_finish();
    end
endmodule : ppdc_top_bench
